// *** design/rci_pkg.sv ***
// constants, types and register map of the row clock and interrupt block
package rci_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int unsigned RCI_CLK_HZ      = 50_000_000;
  localparam int unsigned RCI_ROW_HIGH_MS = 175;
  localparam int unsigned RCI_ROW_LOW_MS  = 25;
  localparam int unsigned RCI_CUE_HIGH_NS = 109_370;
  localparam int unsigned RCI_CUE_LOW_NS  = 15_630;
  // whole cycles; cueing figures round down to stay inside the slot
  localparam int unsigned RCI_ROW_HIGH_CYC =
    RCI_ROW_HIGH_MS * (RCI_CLK_HZ / 1000);
  localparam int unsigned RCI_ROW_LOW_CYC =
    RCI_ROW_LOW_MS * (RCI_CLK_HZ / 1000);
  localparam int unsigned RCI_CUE_HIGH_CYC =
    RCI_CUE_HIGH_NS * (RCI_CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned RCI_CUE_LOW_CYC =
    RCI_CUE_LOW_NS * (RCI_CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned RCI_CNT_W    = 24;
  localparam int unsigned RCI_ROW_W    = 16;
  localparam int unsigned RCI_ROWS_DEF = 600;
  localparam int unsigned RCI_MARK_SLOTS = 8;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int unsigned RCI_AW       = 8;
  localparam logic [7:0]  RCI_OFF_CTRL = 8'h00;
  localparam logic [7:0]  RCI_OFF_MARK = 8'h04;
  localparam logic [7:0]  RCI_OFF_STAT = 8'h08;
  localparam logic [7:0]  RCI_OFF_MASK = 8'h0C;
  localparam logic [7:0]  RCI_OFF_POS  = 8'h10;
  localparam int unsigned RCI_MARK_ROW_LSB = 8;
  localparam int unsigned RCI_ST_FULL  = 0;
  localparam int unsigned RCI_ST_MARK  = 1;
  localparam int unsigned RCI_ST_ROW   = 2;
  localparam int unsigned RCI_ST_W     = 3;
  localparam logic [RCI_ST_W-1:0] RCI_MASK_RST = 3'h0;
  localparam logic [31:0] RCI_ZERO     = 32'h0000_0000;
  localparam logic [1:0]  RCI_OKAY     = 2'h0;
  localparam logic [1:0]  RCI_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    MODE_IDLE, MODE_RECORD, MODE_PLAY, MODE_CUE
  } rci_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE, ST_PRELOAD, ST_HIGH, ST_LOW
  } rci_state_e;

  typedef struct packed {
    logic mark;
    logic full;
  } rci_flags_s;

endpackage

// *** design/rci_sync_fall.sv ***
// two-stage synchroniser with falling-edge pulse for a pin input
`timescale 1ns/1ps
module rci_sync_fall (
  input  wire logic aclk,      // system clock
  input  wire logic aresetn,   // sync reset, active low
  input  wire logic pin_in,    // asynchronous pin level
  output logic      fall       // one-cycle pulse on falling edge
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;
  logic fall_reg, fall_next;

  // edge logic reads only the second stage and its copy
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
    fall_next = last_reg & ~sync_reg;
  end

  // idle level of the select line is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      fall_reg <= fall_next;
    end
  end

  assign fall = fall_reg;
endmodule

// *** design/rci_row_irq.sv ***
// row boundary pulse and message interrupt with axi4-lite registers
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module rci_row_irq #(
  parameter int unsigned ROW_HIGH_CYC = rci_pkg::RCI_ROW_HIGH_CYC,
  parameter int unsigned ROW_LOW_CYC  = rci_pkg::RCI_ROW_LOW_CYC,
  parameter int unsigned CUE_HIGH_CYC = rci_pkg::RCI_CUE_HIGH_CYC,
  parameter int unsigned NUM_ROWS     = rci_pkg::RCI_ROWS_DEF
) (
  input  wire logic                     aclk,          // 50 MHz clock
  input  wire logic                     aresetn,       // sync, active low
  input  wire logic [rci_pkg::RCI_AW-1:0] s_axi_awaddr, // write address
  input  wire logic                     s_axi_awvalid, // aw valid
  output logic                          s_axi_awready, // aw ready
  input  wire logic [31:0]              s_axi_wdata,   // write data
  input  wire logic [3:0]               s_axi_wstrb,   // byte enables
  input  wire logic                     s_axi_wvalid,  // w valid
  output logic                          s_axi_wready,  // w ready
  output logic [1:0]                    s_axi_bresp,   // write response
  output logic                          s_axi_bvalid,  // b valid
  input  wire logic                     s_axi_bready,  // b ready
  input  wire logic [rci_pkg::RCI_AW-1:0] s_axi_araddr, // read address
  input  wire logic                     s_axi_arvalid, // ar valid
  output logic                          s_axi_arready, // ar ready
  output logic [31:0]                   s_axi_rdata,   // read data
  output logic [1:0]                    s_axi_rresp,   // read response
  output logic                          s_axi_rvalid,  // r valid
  input  wire logic                     s_axi_rready,  // r ready
  input  wire logic                     slave_sel_n,   // select pin
  input  wire logic                     read_irq_status_cmd, // status op
  output rci_pkg::rci_flags_s           irq_status,    // status answer
  output logic                          irq_status_valid, // answer pulse
  output logic                          row_boundary_pulse_o,  // pin out
  output logic                          row_boundary_pulse_oe, // drive
  output logic                          int_n_o,       // pin out
  output logic                          int_n_oe,      // drive low
  output logic                          irq            // cpu interrupt
);
  import rci_pkg::*;

  // ****************************************************
  // parameter checks and derived lengths
  // ****************************************************
  if (ROW_HIGH_CYC < 8 || ROW_HIGH_CYC >= (1 << RCI_CNT_W) ||
      ROW_LOW_CYC < 1 || ROW_LOW_CYC >= (1 << RCI_CNT_W) ||
      CUE_HIGH_CYC < 1 || CUE_HIGH_CYC >= (1 << RCI_CNT_W) ||
      NUM_ROWS < 1 || NUM_ROWS >= (1 << RCI_ROW_W)) begin : g_bad
    $error("rci_row_irq: timing or row parameter out of range");
  end

  localparam logic [RCI_CNT_W-1:0] HI_LEN  = RCI_CNT_W'(ROW_HIGH_CYC - 1);
  localparam logic [RCI_CNT_W-1:0] LO_LEN  = RCI_CNT_W'(ROW_LOW_CYC - 1);
  localparam logic [RCI_CNT_W-1:0] CHI_LEN = RCI_CNT_W'(CUE_HIGH_CYC - 1);
  localparam logic [RCI_CNT_W-1:0] CLO_LEN =
    RCI_CNT_W'(RCI_CUE_LOW_CYC - 1);
  // one marker slot is an eighth of a whole row
  localparam logic [RCI_CNT_W-1:0] SEG_LEN =
    RCI_CNT_W'((ROW_HIGH_CYC + ROW_LOW_CYC) / RCI_MARK_SLOTS - 1);
  localparam logic [RCI_ROW_W-1:0] LAST_ROW = RCI_ROW_W'(NUM_ROWS - 1);

  // ****************************************************
  // declarations
  // ****************************************************
  rci_state_e               state_reg, state_next;
  rci_mode_e                mode_reg, mode_next;
  logic [RCI_CNT_W-1:0]     cnt_reg, cnt_next;
  logic [RCI_CNT_W-1:0]     seg_cnt_reg, seg_cnt_next;
  logic [2:0]               seg_reg, seg_next;
  logic [RCI_ROW_W-1:0]     row_reg, row_next;
  logic [31:0]              mark_reg, mark_next;
  logic [RCI_ST_W-1:0]      st_reg, st_next;
  logic [RCI_ST_W-1:0]      mask_reg, mask_next;
  rci_flags_s               pin_reg, pin_next;
  rci_flags_s               ans_reg, ans_next;
  logic                     ans_v_reg, ans_v_next;
  logic                     rbp_oe_reg, rbp_oe_next;
  logic                     int_oe_reg, int_oe_next;
  logic                     irq_reg, irq_next;
  logic                     ev_full, ev_mark, ev_row;
  logic                     ss_fall;
  logic                     start_wr;
  rci_mode_e                wmode;
  logic                     is_play_rec;
  logic                     mark_row_hit;
  logic [RCI_AW-1:0]        awaddr_reg, awaddr_next;
  logic [31:0]              wdata_reg, wdata_next;
  logic [3:0]               wstrb_reg, wstrb_next;
  logic                     aw_have_reg, aw_have_next;
  logic                     w_have_reg, w_have_next;
  logic                     bvalid_reg, bvalid_next;
  logic [1:0]               bresp_reg, bresp_next;
  logic                     arready_reg, arready_next;
  logic                     rvalid_reg, rvalid_next;
  logic [31:0]              rdata_reg, rdata_next;
  logic [1:0]               rresp_reg, rresp_next;
  logic                     do_write, do_read, stat_rd;

  // select pin crosses into the clock domain before use
  rci_sync_fall u_sel (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (slave_sel_n),
    .fall    (ss_fall)
  );

  // merge write data into a register under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************
  // axi4-lite slave
  // ****************************************************
  // address and data are held until both are here, in either order
  always_comb begin
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    do_write     = aw_have_reg & w_have_reg & ~bvalid_reg;
    do_read      = s_axi_arvalid & arready_reg;
    stat_rd      = do_read & (s_axi_araddr == RCI_OFF_STAT);
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (awaddr_reg == RCI_OFF_CTRL ||
                      awaddr_reg == RCI_OFF_MARK ||
                      awaddr_reg == RCI_OFF_MASK ||
                      awaddr_reg == RCI_OFF_STAT ||
                      awaddr_reg == RCI_OFF_POS) ? RCI_OKAY : RCI_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_read) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RCI_OKAY;
      case (s_axi_araddr)
        RCI_OFF_CTRL: rdata_next = {30'h0000_0000, mode_reg};
        RCI_OFF_MARK: rdata_next = mark_reg;
        RCI_OFF_STAT: rdata_next = {29'h0000_0000, st_reg};
        RCI_OFF_MASK: rdata_next = {29'h0000_0000, mask_reg};
        RCI_OFF_POS:  rdata_next = {11'h000, seg_reg, state_reg,
                                    row_reg};
        default: begin
          rdata_next = RCI_ZERO;
          rresp_next = RCI_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  // writes of control start or stop an operation
  assign start_wr = do_write && awaddr_reg == RCI_OFF_CTRL && wstrb_reg[0];
  assign wmode    = rci_mode_e'(wdata_reg[1:0]);

  // ****************************************************
  // row timing engine
  // ****************************************************
  assign is_play_rec  = mode_reg == MODE_RECORD || mode_reg == MODE_PLAY;
  assign mark_row_hit =
    mark_reg[RCI_MARK_ROW_LSB +: RCI_ROW_W] == row_reg;

  // a marker or memory end ends the operation at once
  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    cnt_next     = cnt_reg;
    seg_cnt_next = seg_cnt_reg;
    seg_next     = seg_reg;
    row_next     = row_reg;
    ev_full      = 1'b0;
    ev_mark      = 1'b0;
    ev_row       = 1'b0;
    if (start_wr) begin
      mode_next    = wmode;
      row_next     = '0;
      seg_next     = '0;
      seg_cnt_next = SEG_LEN;
      case (wmode)
        MODE_IDLE:   state_next = ST_IDLE;
        MODE_RECORD: begin
          state_next = ST_PRELOAD;
          cnt_next   = LO_LEN;
        end
        MODE_CUE: begin
          state_next = ST_HIGH;
          cnt_next   = CHI_LEN;
        end
        default: begin
          state_next = ST_HIGH;
          cnt_next   = HI_LEN;
        end
      endcase
    end else begin
      case (state_reg)
        ST_PRELOAD: begin
          // sample and hold stages load while the pin stays released
          if (cnt_reg == '0) begin
            state_next = ST_HIGH;
            cnt_next   = HI_LEN;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        ST_HIGH, ST_LOW: begin
          if (mode_reg == MODE_PLAY) begin
            if (seg_cnt_reg == '0) begin
              seg_cnt_next = SEG_LEN;
              seg_next     = seg_reg + 1'b1;
              if (mark_row_hit && mark_reg[seg_reg]) begin
                ev_mark = 1'b1;
              end
            end else begin
              seg_cnt_next = seg_cnt_reg - 1'b1;
            end
          end
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
          end else if (state_reg == ST_HIGH) begin
            state_next = ST_LOW;
            cnt_next   = (mode_reg == MODE_CUE) ? CLO_LEN : LO_LEN;
          end else begin
            ev_row       = 1'b1;
            seg_next     = '0;
            seg_cnt_next = SEG_LEN;
            if (row_reg == LAST_ROW) begin
              ev_full    = is_play_rec;
              state_next = ST_IDLE;
              mode_next  = MODE_IDLE;
            end else begin
              row_next   = row_reg + 1'b1;
              state_next = ST_HIGH;
              cnt_next   = (mode_reg == MODE_CUE) ? CHI_LEN : HI_LEN;
            end
          end
          if (ev_mark) begin
            state_next = ST_IDLE;
            mode_next  = MODE_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************
  // flags, interrupt pin and status answer
  // ****************************************************
  // a new event in the clearing cycle wins over the clear
  always_comb begin
    pin_next.full = (pin_reg.full & ~ss_fall) | ev_full;
    pin_next.mark = (pin_reg.mark & ~ss_fall) | ev_mark;
    int_oe_next   = pin_next.full | pin_next.mark;
    ans_next     = read_irq_status_cmd ? pin_reg : ans_reg;
    ans_v_next   = read_irq_status_cmd;
    rbp_oe_next  = state_next == ST_LOW;
    mark_next    = mark_reg;
    mask_next    = mask_reg;
    if (do_write && awaddr_reg == RCI_OFF_MARK) begin
      mark_next = merge(mark_reg, wdata_reg, wstrb_reg);
    end
    if (do_write && awaddr_reg == RCI_OFF_MASK && wstrb_reg[0]) begin
      mask_next = wdata_reg[RCI_ST_W-1:0];
    end
    st_next = stat_rd ? '0 : st_reg;
    st_next[RCI_ST_FULL] = st_next[RCI_ST_FULL] | ev_full;
    st_next[RCI_ST_MARK] = st_next[RCI_ST_MARK] | ev_mark;
    st_next[RCI_ST_ROW] = st_next[RCI_ST_ROW] | ev_row;
    irq_next = |(st_next & mask_next);
  end

  // all state registers; outputs come straight from these
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_IDLE;
      mode_reg    <= MODE_IDLE;
      cnt_reg     <= '0;
      seg_cnt_reg <= '0;
      seg_reg     <= '0;
      row_reg     <= '0;
      mark_reg    <= RCI_ZERO;
      st_reg      <= '0;
      mask_reg    <= RCI_MASK_RST;
      pin_reg     <= '0;
      ans_reg     <= '0;
      ans_v_reg   <= 1'b0;
      rbp_oe_reg  <= 1'b0;
      int_oe_reg  <= 1'b0;
      irq_reg     <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= RCI_ZERO;
      wstrb_reg   <= '0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RCI_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= RCI_ZERO;
      rresp_reg   <= RCI_OKAY;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      cnt_reg     <= cnt_next;
      seg_cnt_reg <= seg_cnt_next;
      seg_reg     <= seg_next;
      row_reg     <= row_next;
      mark_reg    <= mark_next;
      st_reg      <= st_next;
      mask_reg    <= mask_next;
      pin_reg     <= pin_next;
      ans_reg     <= ans_next;
      ans_v_reg   <= ans_v_next;
      rbp_oe_reg  <= rbp_oe_next;
      int_oe_reg  <= int_oe_next;
      irq_reg     <= irq_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // open-drain pins only ever pull low
  assign row_boundary_pulse_o  = 1'b0;
  assign row_boundary_pulse_oe = rbp_oe_reg;
  assign int_n_o          = 1'b0;
  assign int_n_oe         = int_oe_reg;
  assign irq              = irq_reg;
  assign irq_status       = ans_reg;
  assign irq_status_valid = ans_v_reg;
  assign s_axi_awready    = ~aw_have_reg;
  assign s_axi_wready     = ~w_have_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;

  // ****************************************************
  // assertions
  // ****************************************************
  a_rbp_low_state: assert property (@(posedge aclk) disable iff (!aresetn)
    row_boundary_pulse_oe == (state_reg == ST_LOW))
    else $error("row pulse drive does not match low phase");
  a_row_low_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(row_boundary_pulse_oe) |-> cnt_reg ==
      ((mode_reg == MODE_CUE) ? CLO_LEN : LO_LEN))
    else $error("row low phase loaded with wrong length");
  a_cue_high_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_LOW && cnt_reg == '0 && mode_reg == MODE_CUE &&
     row_reg != LAST_ROW && !start_wr && !ev_mark)
    |=> state_reg == ST_HIGH && cnt_reg == CHI_LEN)
    else $error("cueing high phase has wrong length");
  a_rec_preload: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_wr && wmode == MODE_RECORD) |=> state_reg == ST_PRELOAD &&
      cnt_reg == LO_LEN ##1 !row_boundary_pulse_oe)
    else $error("record start did not hold pin released");
  a_int_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev_full || ev_mark) |=> int_n_oe && state_reg == ST_IDLE)
    else $error("ending event did not raise interrupt");
  a_int_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (int_n_oe && !ss_fall) |=> int_n_oe)
    else $error("interrupt released without select");
  a_int_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (ss_fall && !ev_full && !ev_mark) |=> !int_n_oe)
    else $error("select fall did not clear interrupt");
  a_int_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (ss_fall && (ev_full || ev_mark)) |=> int_n_oe)
    else $error("event lost against select clear");
  a_full_last_row: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_full |-> row_reg == LAST_ROW && is_play_rec)
    else $error("overflow away from memory end");
  a_mark_play: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_mark |-> mode_reg == MODE_PLAY && mark_reg[seg_reg])
    else $error("end of message outside playback marker");
  a_seg_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_row |=> seg_reg == '0)
    else $error("marker slot index not restarted at row end");
  a_stat_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    read_irq_status_cmd |=> irq_status_valid &&
      irq_status == $past(pin_reg))
    else $error("status answer wrong");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(st_reg & mask_reg))
    else $error("interrupt output disagrees with status");
endmodule

// *** testbench/rci_host_model.sv ***
// host side: pull-ups, select pin and row line meter
`timescale 1ns/1ps
module rci_host_model (
  input  wire logic        aclk,    // clock
  input  wire logic        row_o,   // row level when driven
  input  wire logic        row_oe,  // row drive
  input  wire logic        int_o,   // int level when driven
  input  wire logic        int_oe,  // int drive
  input  wire logic        sel_go,  // start a serial cycle
  output logic             row_pin, // resolved row line
  output logic             int_pin, // resolved int line
  output logic             sel_n,   // select pin
  output logic [15:0]      hi_len,  // last high run
  output logic [15:0]      lo_len   // last low run
);
  logic [15:0] run_reg = 16'h0000;
  logic        prev_reg = 1'b1;
  logic [3:0]  sel_reg = 4'h0;
  // released lines float up to the pull-up level
  assign row_pin = row_oe ? row_o : 1'b1;
  assign int_pin = int_oe ? int_o : 1'b1;
  assign sel_n = (sel_reg == 4'h0);
  // run lengths kept when the row line flips; select held low 8 cycles
  always @(posedge aclk) begin
    if (row_pin != prev_reg) begin
      if (prev_reg) hi_len <= run_reg;
      else lo_len <= run_reg;
      run_reg <= 16'h0001;
    end else run_reg <= run_reg + 16'h0001;
    prev_reg <= row_pin;
    if (sel_go) sel_reg <= 4'h8;
    else if (sel_reg != 4'h0) sel_reg <= sel_reg - 4'h1;
  end
endmodule

// *** testbench/rci_row_irq_bench.sv ***
// self-checking bench for the row clock and interrupt block
`timescale 1ns/1ps
module rci_row_irq_bench;
  import rci_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic cmd = 0, go = 0, awr, wrd, bv, arr, rv, irq, stv, ro, roe, io, ioe;
  logic rp, ip, sel_n;
  logic [7:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] hl, ll;
  rci_flags_s st;
  int error_cnt = 0, samples_checked = 0, n;
  always #10 aclk = ~aclk;
  rci_row_irq #(.ROW_HIGH_CYC(56), .ROW_LOW_CYC(8), .CUE_HIGH_CYC(20),
    .NUM_ROWS(3)) i_rci_row_irq (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .slave_sel_n(sel_n),
    .read_irq_status_cmd(cmd), .irq_status(st), .irq_status_valid(stv),
    .row_boundary_pulse_o(ro), .row_boundary_pulse_oe(roe),
    .int_n_o(io), .int_n_oe(ioe), .irq(irq));
  rci_host_model i_rci_host_model (.aclk(aclk), .row_o(ro), .row_oe(roe),
    .int_o(io), .int_oe(ioe), .sel_go(go), .row_pin(rp), .int_pin(ip),
    .sel_n(sel_n), .hi_len(hl), .lo_len(ll));
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ap = 1, wp = 1, bp = 1;
    @(posedge aclk);
    aa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    while (ap || wp || bp) begin
      @(posedge aclk);
      if (ap && awr) begin ap = 0; awv <= 0; end
      if (wp && wrd) begin wp = 0; wv <= 0; end
      if (bp && bv) begin bp = 0; br <= 0; rs = bresp; end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    bit ap = 1, dp = 1;
    @(posedge aclk);
    ra <= a; arv <= 1; rr <= 1;
    while (ap || dp) begin
      @(posedge aclk);
      if (ap && arr) begin ap = 0; arv <= 0; end
      if (dp && rv) begin dp = 0; rr <= 0; d = rdat; rs = rresp; end
    end
  endtask
  task automatic wt(input logic lv);
    n = 0;
    while (ip !== lv && n < 3000) begin @(posedge aclk); n++; end
    chk("int pin", lv, ip);
  endtask
  // answer is looked at while its one-cycle valid pulse still stands
  task automatic stat_op(input logic [2:0] e);
    @(posedge aclk);
    cmd <= 1;
    @(posedge aclk);
    cmd <= 0;
    @(posedge aclk);
    chk("status answer", e, {st, stv});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict;
  end
  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(RCI_OFF_MASK); chk("mask", 0, d);
    rd(8'h14); chk("resp", RCI_SLVERR, rs);
    wr(8'h14, 0);
    chk("wresp", RCI_SLVERR, rs);
    wr(RCI_OFF_MASK, 3); wr(RCI_OFF_MARK, 32'h0000_0104);
    chk("wresp ok", RCI_OKAY, rs);
    wr(RCI_OFF_CTRL, 2);
    wt(0); chk("irq", 1, irq);
    rd(RCI_OFF_STAT); chk("play stat", 2, d & 3);
    chk("irq clear", 0, irq);
    stat_op(3'h5);
    chk("int held", 0, ip);
    go <= 1; @(posedge aclk); go <= 0; wt(1);
    $display("play test done");
    wr(RCI_OFF_CTRL, 1); n = 0;
    while (rp && n < 200) begin @(posedge aclk); n++; end
    chk("preload", 1, n > 60);
    wt(0); rd(RCI_OFF_STAT); chk("rec stat", 1, d & 3);
    stat_op(3'h3);
    chk("high", 56, hl); chk("low", 8, ll);
    go <= 1; @(posedge aclk); go <= 0; wt(1);
    $display("record test done");
    // a write of the idle mode aborts a running operation
    wr(RCI_OFF_CTRL, 1);
    rd(RCI_OFF_CTRL);
    chk("run mode", 1, d);
    wr(RCI_OFF_CTRL, 0);
    rd(RCI_OFF_CTRL);
    chk("stop mode", 0, d);
    chk("stop pin", 1, rp);
    $display("stop test done");
    wr(RCI_OFF_CTRL, 3); repeat (2500) @(posedge aclk);
    chk("cue hi", 20, hl); chk("cue lo", 781, ll);
    chk("cue int", 1, ip);
    $display("cue test done");
    print_verdict;
  end
endmodule
